//--- shared/aesru_pkg.sv
// Constants, types and shared arithmetic for the scalar AES round unit
`default_nettype none
package aesru_pkg;

  // Instruction field positions
  localparam int OPC_LSB = 0;
  localparam int RD_LSB  = 7;
  localparam int F3_LSB  = 12;
  localparam int F5_LSB  = 25;
  localparam int F7_LSB  = 25;
  localparam int IMM_LSB = 20;
  localparam int BS_LSB  = 30;

  // Major opcodes and minor fields
  localparam logic [6:0]  OPC_REG   = 7'h33;
  localparam logic [6:0]  OPC_IMM   = 7'h13;
  localparam logic [2:0]  F3_ROUND  = 3'h0;
  localparam logic [2:0]  F3_IMIX   = 3'h1;
  localparam logic [4:0]  F5_ES32   = 5'h11;
  localparam logic [4:0]  F5_ESM32  = 5'h13;
  localparam logic [4:0]  F5_DS32   = 5'h15;
  localparam logic [4:0]  F5_DSM32  = 5'h17;
  localparam logic [6:0]  F7_ES64   = 7'h19;
  localparam logic [6:0]  F7_ESM64  = 7'h1B;
  localparam logic [6:0]  F7_DS64   = 7'h1D;
  localparam logic [6:0]  F7_DSM64  = 7'h1F;
  localparam logic [11:0] IMM_IMIX  = 12'h300;

  // Cycles from request to answer, fixed for all data
  localparam int LATENCY = 1;

  // Field constants
  localparam logic [7:0] GF_POLY   = 8'h1B;
  localparam logic [7:0] AFF_FWD_C = 8'h63;
  localparam logic [7:0] AFF_INV_C = 8'h05;
  localparam logic [7:0] INV_EXP   = 8'hFE;
  localparam logic [31:0] MIX_FWD  = 32'h01010302;
  localparam logic [31:0] MIX_INV  = 32'h090D0B0E;

  typedef enum logic [3:0] {
    OP_NONE, OP_ES32, OP_ESM32, OP_DS32, OP_DSM32,
    OP_ES64, OP_ESM64, OP_DS64, OP_DSM64, OP_IM64
  } aesru_op_t;

  // Multiply in the AES field, constant time
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] p;
    acc = 8'h00;
    p   = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        acc = acc ^ p;
      end
      p = {p[6:0], 1'b0} ^ (p[7] ? GF_POLY : 8'h00);
    end
    return acc;
  endfunction : gf_mul

endpackage : aesru_pkg
`default_nettype wire

//--- core/aesru_sbox.sv
// One forward or inverse AES substitution lane, pure logic
`timescale 1ns/1ps
`default_nettype none
module aesru_sbox (
  input  wire logic [7:0] din,  // Byte in
  input  wire logic       inv,  // High selects inverse box
  output logic      [7:0] dout  // Substituted byte
);

  // Field inverse by a fixed power chain, zero maps to zero
  function automatic logic [7:0] gf_inv(input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = a;
    for (int i = 0; i < 8; i++) begin
      if (aesru_pkg::INV_EXP[i]) begin
        r = aesru_pkg::gf_mul(r, p);
      end
      p = aesru_pkg::gf_mul(p, p);
    end
    return r;
  endfunction : gf_inv

  function automatic logic [7:0] rol8(input logic [7:0] a, input int n);
    logic [15:0] t;
    t = {a, a} << n;
    return t[15:8];
  endfunction : rol8

  logic [7:0] pre;
  logic [7:0] mid;

  // Affine step after inverse forward, before inverse backward
  always_comb begin
    pre  = inv ? (rol8(din, 1) ^ rol8(din, 3) ^ rol8(din, 6) ^ aesru_pkg::AFF_INV_C) : din;
    mid  = gf_inv(pre);
    dout = inv ? mid : (mid ^ rol8(mid, 1) ^ rol8(mid, 2) ^ rol8(mid, 3) ^ rol8(mid, 4)
                        ^ aesru_pkg::AFF_FWD_C);
  end

endmodule : aesru_sbox
`default_nettype wire

//--- core/aesru_unit.sv
// Execute-stage scalar AES round unit with fixed one-cycle latency
//
// What this block does
// - RV32 byte forms shift by eight times the byte select and take that byte of rs2's low word.
// - RV32 final encrypt substitutes the byte forward, zero-extends, rotates by the shift and XORs rs1.
// - RV32 middle encrypt adds a partial forward column mix after the forward box before the XOR.
// - RV32 middle decrypt adds a partial inverse column mix after the inverse box before the XOR.
// - RV32 byte form results are sign-extended to the register width and retire normally.
// - Every instruction takes the same number of cycles whatever the operand values.
// - RV64 round forms treat both sources as the 128-bit state and yield one 64-bit half.
// - RV64 final encrypt does forward row shift, keeps the low half, then forward box per byte.
// - RV64 middle encrypt further applies forward column mix to each 32-bit word, upper over lower.
// - RV64 final decrypt does inverse row shift, keeps the low half, then inverse box per byte.
// - RV64 middle decrypt further applies inverse column mix to each word, upper in bits 63..32.
// - A single-source RV64 instruction applies the inverse column mix for key schedule use.
// - That helper mixes the low and high words independently and keeps their positions.
// - RV32 final decrypt substitutes the byte inversely, rotates it into place and XORs rs1.
`timescale 1ns/1ps
`default_nettype none
module aesru_unit #(
  parameter int XLEN    = 64,  // Register width, 32 or 64
  parameter bit HAS_ENC = 1'b1, // Encrypt instructions present
  parameter bit HAS_DEC = 1'b1  // Decrypt instructions present
) (
  input  wire logic            sys_clk,     // Core clock
  input  wire logic            rst,         // Asynchronous reset, active high
  input  wire logic            req_valid,   // Instruction offered this cycle
  input  wire logic [31:0]     req_instr,   // Instruction word
  input  wire logic [XLEN-1:0] req_rs1,     // First source value
  input  wire logic [XLEN-1:0] req_rs2,     // Second source value
  output logic                 rsp_valid,   // Result ready, one-cycle pulse
  output logic      [XLEN-1:0] rsp_data,    // Value for rd
  output logic      [4:0]      rsp_rd,      // Destination index
  output logic                 rsp_illegal  // Instruction not served here
);

  if (XLEN != 32 && XLEN != 64) begin : g_bad_xlen
    $error("aesru_unit: XLEN must be 32 or 64");
  end

  // Row shift on the 128-bit state {hi, lo}, low two columns returned
  function automatic logic [63:0] shift_rows(input logic [63:0] hi, input logic [63:0] lo,
                                             input logic inv);
    logic [127:0] st;
    logic [63:0]  o;
    int           src;
    st = {hi, lo};
    o  = 64'h0;
    for (int c = 0; c < 2; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? (4 * ((c - r + 4) % 4) + r) : (4 * ((c + r) % 4) + r);
        o[8*(4*c+r) +: 8] = st[8*src +: 8];
      end
    end
    return o;
  endfunction : shift_rows

  // Column mix of one word with coefficient row {c3,c2,c1,c0}
  function automatic logic [31:0] mix_col(input logic [31:0] w, input logic [31:0] cf);
    logic [31:0] o;
    logic [7:0]  acc;
    o = 32'h0;
    for (int r = 0; r < 4; r++) begin
      acc = 8'h00;
      for (int k = 0; k < 4; k++) begin
        acc = acc ^ aesru_pkg::gf_mul(w[8*((r+k)%4) +: 8], cf[8*k +: 8]);
      end
      o[8*r +: 8] = acc;
    end
    return o;
  endfunction : mix_col

  function automatic logic [31:0] rol32(input logic [31:0] w, input logic [4:0] s);
    logic [63:0] t;
    t = {w, w} << s;
    return t[63:32];
  endfunction : rol32

  aesru_pkg::aesru_op_t op;
  logic [63:0] rs1_w;
  logic [63:0] rs2_w;
  logic [1:0]  bsel;
  logic [4:0]  shamt;
  logic [7:0]  sel_byte;
  logic [63:0] rows;
  logic        dec_path;
  logic        byte_op;
  logic [63:0] box_in;
  logic [63:0] box_out;
  logic [63:0] imix_src;
  logic [63:0] fmix;
  logic [63:0] imix;
  logic [31:0] word32;
  logic [31:0] res32;
  logic [63:0] res64;
  logic        illegal;

  // Decode and availability check
  always_comb begin
    op      = aesru_pkg::OP_NONE;
    illegal = 1'b1;
    if (req_instr[aesru_pkg::OPC_LSB +: 7] == aesru_pkg::OPC_REG &&
        req_instr[aesru_pkg::F3_LSB +: 3] == aesru_pkg::F3_ROUND) begin
      case (req_instr[aesru_pkg::F7_LSB +: 7])
        aesru_pkg::F7_ES64:  op = aesru_pkg::OP_ES64;
        aesru_pkg::F7_ESM64: op = aesru_pkg::OP_ESM64;
        aesru_pkg::F7_DS64:  op = aesru_pkg::OP_DS64;
        aesru_pkg::F7_DSM64: op = aesru_pkg::OP_DSM64;
        default: begin
          case (req_instr[aesru_pkg::F5_LSB +: 5])
            aesru_pkg::F5_ES32:  op = aesru_pkg::OP_ES32;
            aesru_pkg::F5_ESM32: op = aesru_pkg::OP_ESM32;
            aesru_pkg::F5_DS32:  op = aesru_pkg::OP_DS32;
            aesru_pkg::F5_DSM32: op = aesru_pkg::OP_DSM32;
            default:             op = aesru_pkg::OP_NONE;
          endcase
        end
      endcase
    end else if (req_instr[aesru_pkg::OPC_LSB +: 7] == aesru_pkg::OPC_IMM &&
                 req_instr[aesru_pkg::F3_LSB +: 3] == aesru_pkg::F3_IMIX &&
                 req_instr[aesru_pkg::IMM_LSB +: 12] == aesru_pkg::IMM_IMIX) begin
      op = aesru_pkg::OP_IM64;
    end
    // Availability by option and register width
    case (op)
      aesru_pkg::OP_ES32, aesru_pkg::OP_ESM32:
        illegal = !(HAS_ENC && XLEN == 32);
      aesru_pkg::OP_DS32, aesru_pkg::OP_DSM32:
        illegal = !(HAS_DEC && XLEN == 32);
      aesru_pkg::OP_ES64, aesru_pkg::OP_ESM64:
        illegal = !(HAS_ENC && XLEN == 64);
      aesru_pkg::OP_DS64, aesru_pkg::OP_DSM64, aesru_pkg::OP_IM64:
        illegal = !(HAS_DEC && XLEN == 64);
      default:
        illegal = 1'b1;
    endcase
  end

  // Operand shaping, byte select and row shift
  always_comb begin
    rs1_w    = 64'(req_rs1);
    rs2_w    = 64'(req_rs2);
    bsel     = req_instr[aesru_pkg::BS_LSB +: 2];
    shamt    = {bsel, 3'b000};
    sel_byte = 8'(rs2_w[31:0] >> shamt);
    byte_op  = (op == aesru_pkg::OP_ES32) || (op == aesru_pkg::OP_ESM32) ||
               (op == aesru_pkg::OP_DS32) || (op == aesru_pkg::OP_DSM32);
    dec_path = (op == aesru_pkg::OP_DS32) || (op == aesru_pkg::OP_DSM32) ||
               (op == aesru_pkg::OP_DS64) || (op == aesru_pkg::OP_DSM64);
    rows     = shift_rows(rs2_w, rs1_w, dec_path);
    box_in   = byte_op ? {rows[63:8], sel_byte} : rows;
  end

  // Eight substitution lanes; lane 0 also serves the byte forms
  for (genvar i = 0; i < 8; i++) begin : g_box
    aesru_sbox u_box (
      .din  (box_in[8*i +: 8]),
      .inv  (dec_path),
      .dout (box_out[8*i +: 8])
    );
  end

  // Column mixes and result selection
  always_comb begin
    imix_src = (op == aesru_pkg::OP_IM64) ? rs1_w : box_out;
    fmix     = {mix_col(box_out[63:32], aesru_pkg::MIX_FWD),
                mix_col(box_out[31:0], aesru_pkg::MIX_FWD)};
    imix     = {mix_col(imix_src[63:32], aesru_pkg::MIX_INV),
                mix_col(imix_src[31:0], aesru_pkg::MIX_INV)};
    case (op)
      aesru_pkg::OP_ESM32:
        word32 = {aesru_pkg::gf_mul(box_out[7:0], 8'h03), box_out[7:0], box_out[7:0],
                  aesru_pkg::gf_mul(box_out[7:0], 8'h02)};
      aesru_pkg::OP_DSM32:
        word32 = {aesru_pkg::gf_mul(box_out[7:0], 8'h0B), aesru_pkg::gf_mul(box_out[7:0], 8'h0D),
                  aesru_pkg::gf_mul(box_out[7:0], 8'h09),
                  aesru_pkg::gf_mul(box_out[7:0], 8'h0E)};
      default:
        word32 = {24'h000000, box_out[7:0]};
    endcase
    res32 = rs1_w[31:0] ^ rol32(word32, shamt);
    case (op)
      aesru_pkg::OP_ES32, aesru_pkg::OP_ESM32, aesru_pkg::OP_DS32, aesru_pkg::OP_DSM32:
        res64 = {{32{res32[31]}}, res32};
      aesru_pkg::OP_ES64, aesru_pkg::OP_DS64:
        res64 = box_out;
      aesru_pkg::OP_ESM64:
        res64 = fmix;
      aesru_pkg::OP_DSM64, aesru_pkg::OP_IM64:
        res64 = imix;
      default:
        res64 = 64'h0;
    endcase
  end

  logic            valid_r;
  logic            valid_nxt;
  logic [XLEN-1:0] data_r;
  logic [XLEN-1:0] data_nxt;
  logic [4:0]      rd_r;
  logic [4:0]      rd_nxt;
  logic            ill_r;
  logic            ill_nxt;

  // Answer stage: every request answers exactly one cycle later
  always_comb begin
    valid_nxt = req_valid;
    data_nxt  = (req_valid && !illegal) ? XLEN'(res64) : '0;
    rd_nxt    = req_valid ? req_instr[aesru_pkg::RD_LSB +: 5] : 5'h00;
    ill_nxt   = req_valid && illegal;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      valid_r <= 1'b0;
      data_r  <= '0;
      rd_r    <= 5'h00;
      ill_r   <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
      data_r  <= data_nxt;
      rd_r    <= rd_nxt;
      ill_r   <= ill_nxt;
    end
  end

  assign rsp_valid   = valid_r;
  assign rsp_data    = data_r;
  assign rsp_rd      = rd_r;
  assign rsp_illegal = ill_r;

endmodule : aesru_unit
`default_nettype wire

//--- bench/aesru_unit_properties.sv
// Port checker for the AES round unit
`timescale 1ns/1ps
`default_nettype none
module aesru_properties #(
  parameter int XLEN    = 64,   // Register width
  parameter bit HAS_ENC = 1'b1, // Encrypt forms present
  parameter bit HAS_DEC = 1'b1  // Decrypt forms present
) (
  input wire logic            sys_clk,     // Core clock
  input wire logic            rst,         // Reset
  input wire logic            req_valid,   // Request
  input wire logic [31:0]     req_instr,   // Instruction
  input wire logic [XLEN-1:0] req_rs1,     // Source one
  input wire logic [XLEN-1:0] req_rs2,     // Source two
  input wire logic            rsp_valid,   // Answer
  input wire logic [XLEN-1:0] rsp_data,    // Result
  input wire logic [4:0]      rsp_rd,      // Destination
  input wire logic            rsp_illegal  // Not served
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Decode classes of a request
  sequence s_op(logic [6:0] opc);
    req_valid && req_instr[6:0] == opc && req_instr[14:12] == 3'h0;
  endsequence
  sequence s_rv64;
    s_op(7'h33) ##0 req_instr[31:25] inside {7'h19, 7'h1B, 7'h1D, 7'h1F};
  endsequence
  sequence s_rv32;
    s_op(7'h33) ##0 req_instr[29:25] inside {5'h11, 5'h13, 5'h15, 5'h17};
  endsequence
  sequence s_es64_zero;
    s_rv64 ##0 req_instr[31:25] == 7'h19 && req_rs1 == '0 && req_rs2 == '0;
  endsequence
  property p_rd_carried;
    logic [4:0] rd_v;
    (req_valid, rd_v = req_instr[11:7]) |=> rsp_rd == rd_v;
  endproperty

  chk_answer_next:
    assert property (req_valid |=> rsp_valid) else $error("No answer after request");
  chk_idle_quiet:
    assert property (!req_valid |=> !rsp_valid && rsp_data == '0 && rsp_rd == 5'h0
      && !rsp_illegal) else $error("Output without request");
  chk_rd_carried:
    assert property (p_rd_carried) else $error("Wrong destination index");
  chk_illegal_zero:
    assert property (rsp_illegal |-> rsp_valid && rsp_data == '0) else $error("Illegal with data");
  chk_other_illegal:
    assert property (req_valid && req_instr[6:0] != 7'h33 && req_instr[6:0] != 7'h13
      |=> rsp_illegal) else $error("Foreign word served");
  // Instruction bit 27 set marks a decrypt form, clear an encrypt form
  chk_rv64_width:
    assert property (s_rv64 |=> rsp_illegal == (XLEN != 64 ||
      !($past(req_instr[27]) ? HAS_DEC : HAS_ENC))) else $error("Wide form gating");
  chk_rv32_width:
    assert property (s_rv32 |=> rsp_illegal == (XLEN != 32 ||
      !($past(req_instr[27]) ? HAS_DEC : HAS_ENC))) else $error("Byte form gating");
  chk_es64_zero:
    assert property (s_es64_zero |=> rsp_data ==
      (XLEN == 64 && HAS_ENC ? {(XLEN/8){8'h63}} : '0)) else $error("Zero state round wrong");
endmodule : aesru_properties

bind aesru_unit aesru_properties #(.XLEN(XLEN), .HAS_ENC(HAS_ENC), .HAS_DEC(HAS_DEC)) u_props (
  .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_instr(req_instr),
  .req_rs1(req_rs1), .req_rs2(req_rs2), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_rd(rsp_rd), .rsp_illegal(rsp_illegal));
`default_nettype wire

//--- bench/aesru_core_model.sv
// Issue side of the core: decode slot and register read ports
`timescale 1ns/1ps
`default_nettype none
module aesru_core_model (
  output var logic        req_valid,  // Slot holds an instruction
  output var logic [31:0] req_instr,  // Instruction word
  output var logic [63:0] req_rs1,    // Read port one
  output var logic [63:0] req_rs2     // Read port two
);
  // Empty slot at time zero
  initial begin
    req_valid = 1'b0;
    req_instr = 32'h0;
    req_rs1   = 64'h0;
    req_rs2   = 64'h0;
  end

  // Fill one slot; an empty slot shows scrambled leftovers
  task automatic put(logic v, logic [31:0] i, logic [63:0] a, logic [63:0] b);
    req_valid = v;
    req_instr = v ? i : ~req_instr;
    req_rs1   = v ? a : ~req_rs1;
    req_rs2   = v ? b : ~req_rs2;
  endtask : put
endmodule : aesru_core_model
`default_nettype wire

//--- bench/test_scalar_aes_round_unit.sv
// Self-checking bench for the AES round unit at both register widths
`timescale 1ns/1ps
`default_nettype none
module test_scalar_aes_round_unit;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        req_valid, v64, v32, ill64, ill32, vn, vd, illn, illd;
  logic [31:0] req_instr, ins, d32, dd;
  logic [63:0] req_rs1, req_rs2, d64, dn, a, b;
  logic [4:0]  rd64, rd32;
  logic [7:0]  p;
  logic [7:0]  sb [256];
  logic [7:0]  isb [256];
  int          n_fail = 0;
  int          n_checks = 0;
  int          k;
  logic [31:0] tmpl [10] = '{32'h0, 32'h22000033, 32'h26000033, 32'h2A000033, 32'h2E000033,
    32'h32000033, 32'h36000033, 32'h3A000033, 32'h3E000033, 32'h30001013};
  logic [63:0] pat [4] = '{64'h0, '1, 64'h0123456789ABCDEF, 64'h8000000080000000};

  always #5 sys_clk = ~sys_clk;

  aesru_core_model u_core (.req_valid(req_valid), .req_instr(req_instr), .req_rs1(req_rs1),
    .req_rs2(req_rs2));
  aesru_unit #(.XLEN(64)) dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_instr(req_instr), .req_rs1(req_rs1), .req_rs2(req_rs2), .rsp_valid(v64),
    .rsp_data(d64), .rsp_rd(rd64), .rsp_illegal(ill64));
  aesru_unit #(.XLEN(32)) dut_rv32 (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_instr(req_instr), .req_rs1(req_rs1[31:0]), .req_rs2(req_rs2[31:0]), .rsp_valid(v32),
    .rsp_data(d32), .rsp_rd(rd32), .rsp_illegal(ill32));
  // Option-gated copies: no encrypt forms at 64 bits, no decrypt forms at 32 bits
  aesru_unit #(.XLEN(64), .HAS_ENC(1'b0)) dut_noenc (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req_instr(req_instr), .req_rs1(req_rs1), .req_rs2(req_rs2),
    .rsp_valid(vn), .rsp_data(dn), .rsp_rd(), .rsp_illegal(illn));
  aesru_unit #(.XLEN(32), .HAS_DEC(1'b0)) dut_nodec (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req_instr(req_instr), .req_rs1(req_rs1[31:0]),
    .req_rs2(req_rs2[31:0]), .rsp_valid(vd), .rsp_data(dd), .rsp_rd(), .rsp_illegal(illd));

  // Field arithmetic for the expectations
  function automatic logic [7:0] gm(logic [7:0] x, logic [7:0] y);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (y[i]) r = r ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
    end
    return r;
  endfunction : gm
  function automatic logic [7:0] rl(logic [7:0] v, int n);
    return (v << n) | (v >> (8 - n));
  endfunction : rl
  function automatic logic [31:0] mix(logic [31:0] w, logic inv);
    logic [31:0] c;
    logic [31:0] o;
    c = inv ? 32'h090D0B0E : 32'h01010302;
    o = 32'h0;
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 4; j++)
        o[8*i+:8] = o[8*i+:8] ^ gm(w[8*j+:8], c[8*((j-i)&3)+:8]);
    return o;
  endfunction : mix

  // Operation class of a word: 1-4 byte forms, 5-8 wide rounds, 9 helper
  function automatic int dec(logic [31:0] i);
    if (i[6:0] == 7'h13 && i[14:12] == 3'h1 && i[31:20] == 12'h300) return 9;
    if (i[6:0] != 7'h33 || i[14:12] != 3'h0) return 0;
    for (int j = 1; j < 9; j++)
      if ((j > 4 ? i[31:25] : {2'b00, i[29:25]}) == tmpl[j][31:25]) return j;
    return 0;
  endfunction : dec

  // Expected result of one operation
  function automatic logic [63:0] ex(int op, logic [1:0] bs, logic [63:0] x, logic [63:0] y);
    logic [127:0] st;
    logic [63:0]  o;
    logic [31:0]  w;
    logic [7:0]   s;
    int           c;
    st = {y, x};
    if (op == 9) return {mix(x[63:32], 1'b1), mix(x[31:0], 1'b1)};
    if (op < 5) begin
      s = y[8*bs+:8];
      s = op < 3 ? sb[s] : isb[s];
      w = (op == 2 || op == 4) ? mix({24'h0, s}, op == 4) : {24'h0, s};
      w = x[31:0] ^ ((w << 8*bs) | (w >> (32 - 8*bs)));
      return {{32{w[31]}}, w};
    end
    for (int j = 0; j < 8; j++) begin
      c = op < 7 ? (j / 4 + j % 4) % 4 : (j / 4 - j % 4 + 4) % 4;
      s = st[8*(4*c + j % 4)+:8];
      o[8*j+:8] = op < 7 ? sb[s] : isb[s];
    end
    if (op == 6 || op == 8) o = {mix(o[63:32], op == 8), mix(o[31:0], op == 8)};
    return o;
  endfunction : ex

  // Compare and count
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One request, answer checked one cycle later on both widths
  task automatic send(logic [31:0] i, logic [63:0] x, logic [63:0] y);
    int          op;
    logic [63:0] e;
    op = dec(i);
    e  = ex(op, i[31:30], x, y);
    u_core.put(1'b1, i, x, y);
    @(posedge sys_clk);
    #1;
    check("valid", {62'h0, v64, v32}, 64'h3);
    check("rd", {54'h0, rd64, rd32}, {54'h0, i[11:7], i[11:7]});
    check("illegal", {62'h0, ill64, ill32}, {62'h0, op < 5, op == 0 || op > 4});
    check("data64", d64, op > 4 ? e : 64'h0);
    check("data32", {32'h0, d32}, op > 0 && op < 5 ? {32'h0, e[31:0]} : 64'h0);
    check("gated valid", {62'h0, vn, vd}, 64'h3);
    check("gated illegal", {62'h0, illn, illd}, {62'h0, op < 7, op != 1 && op != 2});
    check("data noenc", dn, op > 6 ? e : 64'h0);
    check("data nodec", {32'h0, dd}, op == 1 || op == 2 ? {32'h0, e[31:0]} : 64'h0);
  endtask : send

  // Empty slot gives a quiet answer
  task automatic idle();
    u_core.put(1'b0, 32'h0, 64'h0, 64'h0);
    @(posedge sys_clk);
    #1;
    check("idle", {50'h0, v64, v32, ill64, ill32, rd64, rd32} | d64 | {32'h0, d32}, 64'h0);
    check("gated idle", {60'h0, vn, vd, illn, illd} | dn | {32'h0, dd}, 64'h0);
  endtask : idle

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: tables, reset, corner sweep, random traffic
  initial begin
    void'($urandom(762));
    for (int x = 0; x < 256; x++) begin
      p = 8'h01;
      for (int j = 0; j < 254; j++) p = gm(p, x[7:0]);
      sb[x] = p ^ rl(p, 1) ^ rl(p, 2) ^ rl(p, 3) ^ rl(p, 4) ^ 8'h63;
      isb[sb[x]] = x[7:0];
    end
    repeat (5) @(posedge sys_clk);
    #1;
    check("reset", {60'h0, v64, v32, vn, vd}, 64'h0);
    rst = 1'b0;
    for (int j = 1; j < 10; j++)
      for (int c = 0; c < 4; c++)
        send(tmpl[j] | (j < 5 ? {c[1:0], 30'h0} : 32'h0) | {20'h0, 5'(j + c), 7'h0},
          pat[c], pat[c & 2]);
    idle();
    $display("corner sweep done");
    for (int n = 0; n < 300; n++) begin
      k   = $urandom_range(9, 0);
      a   = {$urandom, $urandom};
      b   = {$urandom, $urandom};
      ins = k == 0 ? $urandom : tmpl[k] | ($urandom & (k < 5 ? 32'hC1FF8F80 :
        k < 9 ? 32'h01FF8F80 : 32'h000F8F80));
      send(ins, a, b);
      if (k > 4 && k < 9) send(ins, b, a);
      if ($urandom_range(3, 0) == 0) idle();
    end
    $display("random traffic done");
    print_verdict();
  end

  // Watchdog well beyond the expected run
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule : test_scalar_aes_round_unit
`default_nettype wire
